// ===== qvr_consts.svh
// Constants of the queue map and VLAN entry staging register bank.
// Included by the package and the design modules; defines only.
`ifndef QVR_CONSTS_SVH
`define QVR_CONSTS_SVH
`define QVR_ADDR_W 16
`define QVR_OFS_QMC 16'h0390
`define QVR_OFS_VE0 16'h0400
`define QVR_QMC_RESET 32'h0000_0082
`define QVR_QMC_RW_MASK 32'h0000_00ff
`define QVR_VE0_RESET 32'h0000_0000
`define QVR_VE0_RW_MASK 32'h8f00_707f
`define QVR_QMC_MAP_HI 7
`define QVR_QMC_MAP_LO 6
`define QVR_QMC_DISC 1
`define QVR_VE0_VALID 31
`define QVR_VE0_FWD 27
`define QVR_VE0_PRI_HI 26
`define QVR_VE0_PRI_LO 24
`define QVR_VE0_MST_HI 14
`define QVR_VE0_MST_LO 12
`define QVR_VE0_FID_HI 6
`define QVR_VE0_FID_LO 0
`define QVR_MAP_3HI 2'h0
`define QVR_MAP_UNUSED 2'h1
`define QVR_MAP_23HI 2'h2
`define QVR_MAP_123HI 2'h3
`define QVR_READ_ZERO 32'h0000_0000
`endif

// ===== qvr_pkg.sv
// Types shared by the queue map and VLAN entry register bank.
// Assumes qvr_consts.svh is on the include path.
`include "qvr_consts.svh"
package qvr_pkg;
    typedef logic [1:0] qvr_map_t;
    typedef logic [31:0] qvr_word_t;
    typedef enum logic [1:0] {
        QVR_IDLE = 2'b01,
        QVR_RESP = 2'b10
    } qvr_bus_e;
    typedef struct packed {
        qvr_word_t qmc;
        qvr_word_t ve0;
        qvr_word_t rdata;
        logic rvalid;
        qvr_bus_e bus;
    } qvr_regs_s;
    typedef struct packed {
        logic highQueue;
        logic restrict_;
        logic dropMirrored;
    } qvr_fwd_s;
endpackage : qvr_pkg

// ===== qvr_queue_map.sv
// Two-queue mapper: 2-bit regenerated priority to low or high queue.
// Assumes a synchronous clock and reset from the register bank.
`include "qvr_consts.svh"
module qvr_queue_map
    import qvr_pkg::*;
(
    // Clock and control
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Mapping inputs
    input wire logic twoQueueMode,
    input wire qvr_map_t two_queue_priority_map,
    input wire logic [1:0] regenPriority,
    // Result
    output logic highQueue
);
    qvr_fwd_s state;
    qvr_fwd_s next_state;
    // Compare priority with the threshold that the map code selects
    always_comb begin
        next_state = state;
        next_state.restrict_ = 1'b0;
        next_state.dropMirrored = 1'b0;
        if (!twoQueueMode) begin
            next_state.highQueue = 1'b0;
        end else begin
            case (two_queue_priority_map)
                `QVR_MAP_3HI: next_state.highQueue = (regenPriority == 2'h3);
                `QVR_MAP_23HI: next_state.highQueue = regenPriority[1];
                `QVR_MAP_123HI: next_state.highQueue = (regenPriority != 2'h0);
                default: next_state.highQueue = regenPriority[1]; // Unused code acts as reset map
            endcase
        end
    end
    // Register the result
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= '0;
        end else if (clkEn) begin
            state <= next_state;
        end
    end
    assign highQueue = state.highQueue;
endmodule : qvr_queue_map

// ===== qvr_member_filter.sv
// Unicast membership filter: restricts destinations to membership ports.
// Assumes port maps are valid in the same cycle as frameMirrored.
`include "qvr_consts.svh"
module qvr_member_filter
    import qvr_pkg::*;
#(
    parameter int PORTS = 3
) (
    // Clock and control
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Settings and frame information
    input wire logic membershipDiscard,
    input wire logic mirrorActive,
    input wire logic frameMirrored,
    input wire logic [PORTS-1:0] destPorts,
    input wire logic [PORTS-1:0] memberPorts,
    // Result
    output logic [PORTS-1:0] egressPorts,
    output logic dropFrame
);
    logic [PORTS-1:0] ports;
    logic [PORTS-1:0] next_ports;
    logic drop;
    logic next_drop;
    logic single;
    // Refuse port counts that the logic cannot serve
    if (PORTS < 1 || PORTS > 16) begin : gBadPorts
        $error("PORTS out of range");
    end
    // One destination exactly
    assign single = (destPorts != '0) && ((destPorts & (destPorts - 1'b1)) == '0);
    // Apply membership masking and the mirrored single-destination drop
    always_comb begin
        next_drop = 1'b0;
        if (membershipDiscard || !single) begin
            next_ports = destPorts & memberPorts;
        end else begin
            next_ports = destPorts;
            if (mirrorActive && frameMirrored) begin
                next_drop = 1'b1;
                next_ports = '0;
            end
        end
    end
    // Register results
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ports <= '0;
            drop <= 1'b0;
        end else if (clkEn) begin
            ports <= next_ports;
            drop <= next_drop;
        end
    end
    assign egressPorts = ports;
    assign dropFrame = drop;
endmodule : qvr_member_filter

// ===== qvr_regs.sv
// Queue management control and VLAN entry word zero, with decisions.
// Assumes a simple synchronous register port from management logic.
// Operation
// - Map code 00 sends priorities 0 to 2 low and 3 high; 01 is not used.
// - Map code 10, the reset value, sends 0 and 1 low and 2 and 3 high.
// - Map code 11 sends only 0 low and 1 to 3 high.
// - The map applies only on two-queue ports, on the 2-bit regenerated priority.
// - With the discard bit set (reset), all frames keep to membership ports.
// - With it clear, single-destination frames ignore membership ports.
// - With it clear and mirroring on, a mirrored single-destination frame drops.
// - Entry bit 31 marks the entry valid.
// - Entry bit 27 set forwards to the entry's own port map.
// - Entry bit 27 clear takes egress ports from other sources.
// - Entry bits 26:24 hold the entry priority.
// - Entry bits 14:12 hold the spanning tree instance.
// - Entry bits 6:0 hold the filter identifier used for lookup hashing.
`include "qvr_consts.svh"
module qvr_regs
    import qvr_pkg::*;
#(
    parameter int PORTS = 3
) (
    // Clock and control
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Register port
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [`QVR_ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic [3:0] regBe,
    output logic [31:0] regRdata,
    output logic regRvalid,
    // Table engine load of the staged entry on a table read
    input wire logic entryLoad,
    input wire logic [31:0] entryLoadData,
    // Queue mapping
    input wire logic twoQueueMode,
    input wire logic [1:0] regenPriority,
    output logic highQueue,
    // Membership filtering
    input wire logic mirrorActive,
    input wire logic frameMirrored,
    input wire logic [PORTS-1:0] destPorts,
    input wire logic [PORTS-1:0] memberPorts,
    output logic [PORTS-1:0] egressPorts,
    output logic dropFrame,
    // Staged entry fields
    output logic entryValid,
    output logic entryForwardOption,
    output logic [2:0] entryPriority,
    output logic [2:0] spanning_tree_instance,
    output logic [6:0] filter_identifier
);
    qvr_regs_s r;
    qvr_regs_s next_r;
    logic [31:0] beMask;
    // Refuse port counts that the filter cannot serve
    if (PORTS < 1 || PORTS > 16) begin : gBadPorts
        $error("PORTS out of range");
    end
    // Byte enables widened to a bit mask
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gBe
            assign beMask[g*8 +: 8] = {8{regBe[g]}};
        end
    endgenerate
    // Register writes, reads and staged entry load
    always_comb begin
        next_r = r;
        next_r.rvalid = 1'b0;
        next_r.bus = QVR_IDLE;
        if (regWrite && regAddr == `QVR_OFS_QMC) begin
            next_r.qmc = (r.qmc & ~(beMask & `QVR_QMC_RW_MASK))
                | (regWdata & beMask & `QVR_QMC_RW_MASK);
        end
        if (entryLoad) begin
            next_r.ve0 = entryLoadData & `QVR_VE0_RW_MASK;
        end else if (regWrite && regAddr == `QVR_OFS_VE0) begin
            next_r.ve0 = (r.ve0 & ~(beMask & `QVR_VE0_RW_MASK))
                | (regWdata & beMask & `QVR_VE0_RW_MASK);
        end
        if (regRead) begin
            next_r.rvalid = 1'b1;
            next_r.bus = QVR_RESP;
            case (regAddr)
                `QVR_OFS_QMC: next_r.rdata = r.qmc;
                `QVR_OFS_VE0: next_r.rdata = r.ve0;
                default: next_r.rdata = `QVR_READ_ZERO;
            endcase
        end
    end
    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r.qmc <= `QVR_QMC_RESET;
            r.ve0 <= `QVR_VE0_RESET;
            r.rdata <= `QVR_READ_ZERO;
            r.rvalid <= 1'b0;
            r.bus <= QVR_IDLE;
        end else if (clkEn) begin
            r <= next_r;
        end
    end
    assign regRdata = r.rdata;
    assign regRvalid = r.rvalid;
    // Staged entry fields straight from the register
    assign entryValid = r.ve0[`QVR_VE0_VALID];
    assign entryForwardOption = r.ve0[`QVR_VE0_FWD];
    assign entryPriority = r.ve0[`QVR_VE0_PRI_HI:`QVR_VE0_PRI_LO];
    assign spanning_tree_instance = r.ve0[`QVR_VE0_MST_HI:`QVR_VE0_MST_LO];
    assign filter_identifier = r.ve0[`QVR_VE0_FID_HI:`QVR_VE0_FID_LO];
    // Queue mapper
    qvr_queue_map uMap (
        .clk(clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .twoQueueMode(twoQueueMode),
        .two_queue_priority_map(r.qmc[`QVR_QMC_MAP_HI:`QVR_QMC_MAP_LO]),
        .regenPriority(regenPriority),
        .highQueue(highQueue)
    );
    // Membership filter
    qvr_member_filter #(.PORTS(PORTS)) uFilt (
        .clk(clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .membershipDiscard(r.qmc[`QVR_QMC_DISC]),
        .mirrorActive(mirrorActive),
        .frameMirrored(frameMirrored),
        .destPorts(destPorts),
        .memberPorts(memberPorts),
        .egressPorts(egressPorts),
        .dropFrame(dropFrame)
    );
endmodule : qvr_regs

// ===== qvr_regs_properties.sv
// Port checker for the queue map and VLAN entry register bank.
// Bound to qvr_regs; one clock, synchronous active-low reset.
`include "qvr_consts.svh"
module qvr_regs_properties #(
    parameter int PORTS = 3
) (
    // Clock, reset and register port
    input wire logic clk, rst_n, clkEn, regRead, regRvalid,
    input wire logic [`QVR_ADDR_W-1:0] regAddr,
    input wire logic [31:0] regRdata,
    // Entry load and fields
    input wire logic entryLoad, entryValid,
    input wire logic [31:0] entryLoadData,
    input wire logic [6:0] filter_identifier,
    // Queue map and filter
    input wire logic twoQueueMode, highQueue, mirrorActive, frameMirrored, dropFrame,
    input wire logic [1:0] regenPriority,
    input wire logic [PORTS-1:0] destPorts, memberPorts, egressPorts
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Read request at a given address
    sequence s_rd(a);
        clkEn && regRead && regAddr == a;
    endsequence
    // Register port answers
    a_read_pulse: assert property (clkEn |=> regRvalid == $past(regRead))
        else $error("read answer pulse wrong");
    a_qmc_resv: assert property (s_rd(`QVR_OFS_QMC) |=> regRdata[31:8] == 24'h0)
        else $error("queue control reserved bits not zero");
    a_ve0_resv: assert property (s_rd(`QVR_OFS_VE0) |=> (regRdata & ~`QVR_VE0_RW_MASK) == 32'h0)
        else $error("entry reserved bits not zero");
    a_unmapped_zero: assert property (clkEn && regRead && regAddr != `QVR_OFS_QMC
        && regAddr != `QVR_OFS_VE0 |=> regRdata == 32'h0)
        else $error("unmapped read not zero");
    // Queue selection
    a_mode_off: assert property (clkEn && !twoQueueMode |=> !highQueue)
        else $error("high queue outside two-queue mode");
    a_pri_three: assert property (clkEn && twoQueueMode && regenPriority == 2'h3 |=> highQueue)
        else $error("priority three not high");
    a_pri_zero: assert property (clkEn && twoQueueMode && regenPriority == 2'h0 |=> !highQueue)
        else $error("priority zero not low");
    // Membership filter
    a_multi_dest: assert property (clkEn && $countones(destPorts) != 1
        |=> egressPorts == ($past(destPorts) & $past(memberPorts)) && !dropFrame)
        else $error("multi-destination not restricted");
    a_drop_cause: assert property (clkEn && !(mirrorActive && frameMirrored) |=> !dropFrame)
        else $error("drop without mirroring");
    a_drop_empty: assert property (dropFrame |-> egressPorts == '0)
        else $error("dropped frame has ports");
    // Staged entry load
    a_load_fields: assert property (clkEn && entryLoad |=> entryValid == $past(entryLoadData[31])
        && filter_identifier == $past(entryLoadData[6:0]))
        else $error("entry load fields wrong");
endmodule : qvr_regs_properties

bind qvr_regs qvr_regs_properties #(.PORTS(PORTS)) chk (.clk, .rst_n, .clkEn, .regRead, .regRvalid,
    .regAddr, .regRdata, .entryLoad, .entryValid, .entryLoadData, .filter_identifier, .twoQueueMode,
    .highQueue, .mirrorActive, .frameMirrored, .dropFrame, .regenPriority, .destPorts, .memberPorts,
    .egressPorts);

// ===== tb.sv
// Self-checking bench for the queue map and VLAN entry register bank.
// Inputs change at the falling edge; the port checker is bound separately.
`include "qvr_consts.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, regWrite = 1'b0, regRead = 1'b0, entryLoad = 1'b0;
    logic twoQueueMode = 1'b0, mirrorActive = 1'b0, frameMirrored = 1'b0;
    logic regRvalid, highQueue, dropFrame, entryValid, entryForwardOption;
    logic [15:0] regAddr = 16'h0;
    logic [31:0] regWdata = 32'h0, entryLoadData = 32'h0, regRdata;
    logic [3:0] regBe = 4'hf;
    logic [1:0] regenPriority = 2'h0;
    logic [2:0] destPorts = 3'h0, memberPorts = 3'h0, egressPorts, entryPriority, spanning_tree_instance;
    logic [6:0] filter_identifier;
    int n_mismatch = 0, n_checks = 0, cyc = 0;
    qvr_regs uut (.clk, .rst_n, .clkEn, .regWrite, .regRead, .regAddr, .regWdata, .regBe, .regRdata,
        .regRvalid, .entryLoad, .entryLoadData, .twoQueueMode, .regenPriority, .highQueue, .mirrorActive,
        .frameMirrored, .destPorts, .memberPorts, .egressPorts, .dropFrame, .entryValid,
        .entryForwardOption, .entryPriority, .spanning_tree_instance, .filter_identifier);
    // Clock and hang guard
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            test_done();
        end
    end
    task automatic test_done();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One register write, held over one rising edge
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] be);
        @(negedge clk);
        regWrite = 1'b1;
        regAddr = a;
        regWdata = d;
        regBe = be;
        @(negedge clk);
        regWrite = 1'b0;
    endtask : wr
    // One register read; answer checked in its single valid cycle
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        @(negedge clk);
        regRead = 1'b1;
        regAddr = a;
        @(negedge clk);
        regRead = 1'b0;
        chk({31'h0, regRvalid}, 32'h1);
        chk(regRdata, exp);
    endtask : rd
    task automatic t_map();
        logic [5:0] codes = 6'b111000;
        logic [5:0] thr = 6'b011011;
        for (int c = 0; c < 3; c++) begin
            wr(`QVR_OFS_QMC, {24'h0, codes[2*c+:2], 6'h02}, 4'hf);
            for (int p = 0; p < 4; p++) begin
                twoQueueMode = 1'b1;
                regenPriority = p[1:0];
                @(negedge clk);
                chk({31'h0, highQueue}, {31'h0, p >= thr[2*c+:2]});
            end
        end
        twoQueueMode = 1'b0;
        @(negedge clk);
        chk({31'h0, highQueue}, 32'h0);
    endtask : t_map
    task automatic t_regs();
        wr(`QVR_OFS_QMC, 32'hffffffff, 4'hf);
        rd(`QVR_OFS_QMC, 32'h000000ff);
        wr(`QVR_OFS_VE0, 32'hffffffff, 4'hf);
        rd(`QVR_OFS_VE0, 32'h8f00707f);
        wr(`QVR_OFS_VE0, 32'h0, 4'h7);
        rd(`QVR_OFS_VE0, 32'h8f000000);
        wr(`QVR_OFS_VE0, 32'h82005023, 4'hf);
        chk({17'h0, entryValid, entryForwardOption, entryPriority, spanning_tree_instance, filter_identifier},
            {17'h0, 1'b1, 1'b0, 3'h2, 3'h5, 7'h23});
        wr(16'h0394, 32'hffffffff, 4'hf);
        rd(16'h0394, 32'h0);
    endtask : t_regs
    task automatic t_filter();
        wr(`QVR_OFS_QMC, 32'h82, 4'hf);
        destPorts = 3'h1;
        memberPorts = 3'h6;
        @(negedge clk);
        chk({dropFrame, egressPorts}, 32'h0);
        wr(`QVR_OFS_QMC, 32'h80, 4'hf);
        @(negedge clk);
        chk({dropFrame, egressPorts}, 32'h1);
        mirrorActive = 1'b1;
        frameMirrored = 1'b1;
        @(negedge clk);
        chk({dropFrame, egressPorts}, 32'h8);
        destPorts = 3'h3;
        memberPorts = 3'h2;
        @(negedge clk);
        chk({dropFrame, egressPorts}, 32'h2);
    endtask : t_filter
    task automatic t_load();
        entryLoadData = 32'h8b003055;
        entryLoad = 1'b1;
        @(negedge clk);
        entryLoad = 1'b0;
        rd(`QVR_OFS_VE0, 32'h8b003055);
        chk({17'h0, entryValid, entryForwardOption, entryPriority, spanning_tree_instance, filter_identifier},
            {17'h0, 1'b1, 1'b1, 3'h3, 3'h3, 7'h55});
    endtask : t_load
    // Main sequence
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        rd(`QVR_OFS_QMC, `QVR_QMC_RESET);
        rd(`QVR_OFS_VE0, 32'h0);
        t_map();
        t_regs();
        t_filter();
        t_load();
        test_done();
    end
endmodule : tb
